// ==== shared/logic_eval_pkg.sv ====
// Shared constants and types for the postfix logic evaluator
package logic_eval_pkg;
	localparam int LIST_DEPTH = 512;
	localparam int ADDR_W     = 9;
	localparam int ARG_W      = 7;
	localparam int ENTRY_W    = 11;
	localparam int N_INPUTS   = 128;
	localparam int N_TIMERS   = 32;
	localparam int N_SOFT     = 96;
	localparam int N_ONESHOT  = 64;
	localparam int N_LATCH    = 16;
	localparam int STACK_W    = 32;
	localparam int GATE_W     = 16;
	localparam logic [4:0] GATE_MIN = 5'h02;
	localparam logic [4:0] GATE_MAX = 5'h10;
	localparam logic [ADDR_W-1:0] LAST_ADDR  = 9'h1FF;
	localparam logic [ADDR_W-1:0] FIRST_ADDR = 9'h000;
	localparam logic [ARG_W-1:0] SOFT_LIMIT = 7'h60;

	// Operation codes follow declaration order, 0 through 15
	typedef enum logic [3:0] {
		OP_END, OP_IN, OP_SOFT, OP_CONST, OP_NOT, OP_OR, OP_AND, OP_NOR,
		OP_NAND, OP_XOR, OP_LATCH, OP_OS_RISE, OP_OS_FALL, OP_OS_BOTH, OP_TIMER,
		OP_ASSIGN
	} op_type;

	typedef struct packed {
		op_type           op;
		logic [ARG_W-1:0] arg;
	} entry_type;

	typedef enum logic [1:0] {ST_COMPILE, ST_IDLE, ST_EVAL} state_type;

	localparam entry_type ENTRY_RESET = '{op: OP_END, arg: 7'h00};
endpackage

// ==== shared/stack_if.sv ====
// Result stack control and view shared by evaluator and stack store
interface stack_if;
	logic        clr;
	logic        push;
	logic        push_val;
	logic [4:0]  pop_n;
	logic [15:0] top;

	modport user  (output clr, output push, output push_val, output pop_n, input top);
	modport store (input clr, input push, input push_val, input pop_n, output top);
endinterface

// ==== core/eval_stack.sv ====
// Bit stack of intermediate results, newest result in bit 0
module eval_stack (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Control from the evaluator
	stack_if.store    stk
);
	logic [logic_eval_pkg::STACK_W-1:0] stack_r;
	logic [logic_eval_pkg::STACK_W-1:0] stack_nxt;

	// Pop first, then push; underflow shifts in zeros, overflow drops the oldest
	always_comb begin
		stack_nxt = stack_r >> stk.pop_n;
		if (stk.push) begin
			stack_nxt = {stack_nxt[logic_eval_pkg::STACK_W-2:0], stk.push_val};
		end
		if (stk.clr) begin
			stack_nxt = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stack_r <= '0;
		end else begin
			stack_r <= stack_nxt;
		end
	end

	assign stk.top = stack_r[logic_eval_pkg::GATE_W-1:0];

	a_stack_push: assert property (@(posedge clk) disable iff (!rst_n)
		(!stk.clr && stk.push) |=> (stack_r[0] == $past(stk.push_val)))
		else $error("pushed result not on top");
endmodule

// ==== core/dup_checker.sv ====
// Tracks timer and soft output use during compile and flags repeats
module dup_checker (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Compile scan
	input  wire logic       clr,
	input  wire logic       mark_timer,
	input  wire logic       mark_soft,
	input  wire logic [6:0] idx,
	// Result
	output logic            dup_err
);
	logic [logic_eval_pkg::N_TIMERS-1:0] used_t_r, used_t_nxt;
	logic [logic_eval_pkg::N_SOFT-1:0]   used_s_r, used_s_nxt;
	logic                                err_r, err_nxt;
	logic                                hit;

	// A repeat, or an assignment past the last soft output, is a syntax error
	always_comb begin
		used_t_nxt = clr ? '0 : used_t_r;
		used_s_nxt = clr ? '0 : used_s_r;
		err_nxt    = clr ? 1'b0 : err_r;
		hit        = 1'b0;
		if (mark_timer) begin
			hit = used_t_r[idx[4:0]];
			used_t_nxt[idx[4:0]] = 1'b1;
		end
		if (mark_soft) begin
			if (idx >= logic_eval_pkg::SOFT_LIMIT) begin
				hit = 1'b1;
			end else begin
				hit = used_s_r[idx];
				used_s_nxt[idx] = 1'b1;
			end
		end
		// Set wins over clear so a repeat found in a clear cycle is kept
		if (hit) begin
			err_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			used_t_r <= '0;
			used_s_r <= '0;
			err_r    <= 1'b0;
		end else begin
			used_t_r <= used_t_nxt;
			used_s_r <= used_s_nxt;
			err_r    <= err_nxt;
		end
	end

	assign dup_err = err_r;

	a_dup_timer: assert property (@(posedge clk) disable iff (!rst_n)
		(mark_timer && used_t_r[idx[4:0]]) |=> dup_err)
		else $error("repeated timer not flagged");
endmodule

// ==== core/logic_evaluator.sv ====
// Postfix Boolean equation evaluator: list store, compile check, scan walk
// Functional notes
// - AND/NOR/NAND(n) reduce n newest results, n 2..16
// - XOR takes two newest, true if exactly one
// - Latch: newest is reset, one before is set
// - Latch reset dominates set
// - Latch holds set until reset
// - 32 timers, started by newest result, output pushed
// - 96 soft output assigns from newest result
// - Assignment ends equation; stack starts fresh
// - Repeated timer or assignment flags syntax error
// - Entries evaluated strictly in entry order
// - Latches cleared at power-up
// - Any setting write recompiles and clears latches
// - First end marker stops the pass
// - OR any, AND all, NOR none, NAND not-all, NOT inverts
// - One-shots pulse one pass per edge, 64 max
module logic_evaluator (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Settings write port into the list
	input  wire logic         set_wr,
	input  wire logic [8:0]   set_addr,
	input  wire logic [10:0]  set_data,
	// Scan control
	input  wire logic         scan_stb,
	output logic              scan_busy,
	output logic              scan_done,
	output logic              syntax_err,
	// Operands from the rest of the device
	input  wire logic [127:0] operand_in,
	// Timer elements outside this block
	output logic [31:0]       timer_start,
	input  wire logic [31:0]  timer_out,
	// Results
	output logic [95:0]       soft_output
);
	stack_if stk ();

	logic [logic_eval_pkg::ENTRY_W-1:0]   list_r [logic_eval_pkg::LIST_DEPTH];
	logic_eval_pkg::state_type             state_r, state_nxt;
	logic [logic_eval_pkg::ADDR_W-1:0]     addr_r, addr_nxt;
	logic [logic_eval_pkg::N_SOFT-1:0]     soft_r, soft_nxt;
	logic [logic_eval_pkg::N_TIMERS-1:0]   tstart_r, tstart_nxt;
	logic [logic_eval_pkg::N_LATCH-1:0]    latch_r, latch_nxt;
	logic [logic_eval_pkg::N_ONESHOT-1:0]  os_prev_r, os_prev_nxt;
	logic                                  done_r, done_nxt;
	logic_eval_pkg::entry_type             entry;
	logic                                  ev;
	logic                                  is_last;
	logic                                  chk_clr, mark_timer, mark_soft;
	logic                                  dup_err;
	logic                                  latch_q;
	logic [4:0]                            gate_n;

	// Clamp a gate's input count to the supported range
	function automatic logic [4:0] gate_count(input logic [6:0] arg);
		if (arg < 7'(logic_eval_pkg::GATE_MIN)) begin
			return logic_eval_pkg::GATE_MIN;
		end
		if (arg > 7'(logic_eval_pkg::GATE_MAX)) begin
			return logic_eval_pkg::GATE_MAX;
		end
		return arg[4:0];
	endfunction

	// Reduce the n newest results for one multi-input gate
	function automatic logic gate_eval(input logic_eval_pkg::op_type op, input logic [15:0] s,
		input logic [4:0] n);
		logic [15:0] m;
		logic        any1;
		logic        all1;
		m    = 16'hFFFF >> (5'h10 - n);
		any1 = |(s & m);
		all1 = &(s | ~m);
		case (op)
			logic_eval_pkg::OP_OR:   return any1;
			logic_eval_pkg::OP_AND:  return all1;
			logic_eval_pkg::OP_NOR:  return !any1;
			logic_eval_pkg::OP_NAND: return !all1;
			default:                 return 1'b0;
		endcase
	endfunction

	eval_stack u_stack (
		.clk   (clk),
		.rst_n (rst_n),
		.stk   (stk)
	);

	dup_checker u_dup (
		.clk        (clk),
		.rst_n      (rst_n),
		.clr        (chk_clr),
		.mark_timer (mark_timer),
		.mark_soft  (mark_soft),
		.idx        (entry.arg),
		.dup_err    (dup_err)
	);

	// List storage; every write also forces a recompile below
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < logic_eval_pkg::LIST_DEPTH; i++) begin
				list_r[i] <= logic_eval_pkg::ENTRY_RESET;
			end
		end else if (set_wr) begin
			list_r[set_addr] <= set_data;
		end
	end

	assign entry   = logic_eval_pkg::entry_type'(list_r[addr_r]);
	assign is_last = (addr_r == logic_eval_pkg::LAST_ADDR);
	assign ev      = (state_r == logic_eval_pkg::ST_EVAL) && !set_wr;
	assign gate_n  = gate_count(entry.arg);
	// Reset-dominant: reset input on top, set input one below
	assign latch_q = stk.top[0] ? 1'b0 : (stk.top[1] | latch_r[entry.arg[3:0]]);

	// Sequencer and operator execution
	always_comb begin
		state_nxt    = state_r;
		addr_nxt     = addr_r;
		soft_nxt     = soft_r;
		tstart_nxt   = tstart_r;
		latch_nxt    = latch_r;
		os_prev_nxt  = os_prev_r;
		done_nxt     = 1'b0;
		chk_clr      = 1'b0;
		mark_timer   = 1'b0;
		mark_soft    = 1'b0;
		stk.clr      = 1'b0;
		stk.push     = 1'b0;
		stk.push_val = 1'b0;
		stk.pop_n    = 5'h00;
		case (state_r)
			logic_eval_pkg::ST_COMPILE: begin
				// Syntax pass over the list up to the first end marker
				// A write in this cycle restarts the scan, so it must not leave a use behind
				mark_timer = (entry.op == logic_eval_pkg::OP_TIMER) && !set_wr;
				mark_soft  = (entry.op == logic_eval_pkg::OP_ASSIGN) && !set_wr;
				if (entry.op == logic_eval_pkg::OP_END || is_last) begin
					state_nxt = logic_eval_pkg::ST_IDLE;
					addr_nxt  = logic_eval_pkg::FIRST_ADDR;
				end else begin
					addr_nxt = addr_r + 9'h001;
				end
			end
			logic_eval_pkg::ST_IDLE: begin
				// A faulty list is never run, so outputs keep their last values
				if (scan_stb && !dup_err) begin
					state_nxt = logic_eval_pkg::ST_EVAL;
					addr_nxt  = logic_eval_pkg::FIRST_ADDR;
					stk.clr   = 1'b1;
				end
			end
			logic_eval_pkg::ST_EVAL: begin
				case (entry.op)
					logic_eval_pkg::OP_IN: begin
						stk.push     = 1'b1;
						stk.push_val = operand_in[entry.arg];
					end
					logic_eval_pkg::OP_SOFT: begin
						// Value from this pass if already assigned, else from the last
						stk.push     = 1'b1;
						stk.push_val = (entry.arg < logic_eval_pkg::SOFT_LIMIT) && soft_r[entry.arg];
					end
					logic_eval_pkg::OP_CONST: begin
						stk.push     = 1'b1;
						stk.push_val = entry.arg[0];
					end
					logic_eval_pkg::OP_NOT: begin
						stk.pop_n    = 5'h01;
						stk.push     = 1'b1;
						stk.push_val = !stk.top[0];
					end
					logic_eval_pkg::OP_OR, logic_eval_pkg::OP_AND, logic_eval_pkg::OP_NOR,
					logic_eval_pkg::OP_NAND: begin
						stk.pop_n    = gate_n;
						stk.push     = 1'b1;
						stk.push_val = gate_eval(entry.op, stk.top, gate_n);
					end
					logic_eval_pkg::OP_XOR: begin
						stk.pop_n    = 5'h02;
						stk.push     = 1'b1;
						stk.push_val = stk.top[0] ^ stk.top[1];
					end
					logic_eval_pkg::OP_LATCH: begin
						stk.pop_n    = 5'h02;
						stk.push     = 1'b1;
						stk.push_val = latch_q;
						latch_nxt[entry.arg[3:0]] = latch_q;
					end
					logic_eval_pkg::OP_OS_RISE, logic_eval_pkg::OP_OS_FALL,
					logic_eval_pkg::OP_OS_BOTH: begin
						// Edge against the input seen on the previous pass
						stk.pop_n = 5'h01;
						stk.push  = 1'b1;
						stk.push_val = ((entry.op != logic_eval_pkg::OP_OS_FALL) && stk.top[0]
							&& !os_prev_r[entry.arg[5:0]]) || ((entry.op != logic_eval_pkg::OP_OS_RISE)
							&& !stk.top[0] && os_prev_r[entry.arg[5:0]]);
						os_prev_nxt[entry.arg[5:0]] = stk.top[0];
					end
					logic_eval_pkg::OP_TIMER: begin
						stk.pop_n    = 5'h01;
						stk.push     = 1'b1;
						stk.push_val = timer_out[entry.arg[4:0]];
						tstart_nxt[entry.arg[4:0]] = stk.top[0];
					end
					logic_eval_pkg::OP_ASSIGN: begin
						if (entry.arg < logic_eval_pkg::SOFT_LIMIT) begin
							soft_nxt[entry.arg] = stk.top[0];
						end
						stk.clr = 1'b1;
					end
					default: begin
					end
				endcase
				// Stop at the first end marker or at the last entry
				if (entry.op == logic_eval_pkg::OP_END || is_last) begin
					state_nxt = logic_eval_pkg::ST_IDLE;
					addr_nxt  = logic_eval_pkg::FIRST_ADDR;
					done_nxt  = 1'b1;
				end else begin
					addr_nxt = addr_r + 9'h001;
				end
			end
			default: begin
				state_nxt = logic_eval_pkg::ST_COMPILE;
				addr_nxt  = logic_eval_pkg::FIRST_ADDR;
			end
		endcase
		// A settings write aborts any pass, clears latches and recompiles
		if (set_wr) begin
			state_nxt   = logic_eval_pkg::ST_COMPILE;
			addr_nxt    = logic_eval_pkg::FIRST_ADDR;
			latch_nxt   = '0;
			os_prev_nxt = '0;
			chk_clr     = 1'b1;
			stk.clr     = 1'b1;
			done_nxt    = 1'b0;
		end
	end

	// Power-up starts a compile with every latch reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r   <= logic_eval_pkg::ST_COMPILE;
			addr_r    <= logic_eval_pkg::FIRST_ADDR;
			soft_r    <= '0;
			tstart_r  <= '0;
			latch_r   <= '0;
			os_prev_r <= '0;
			done_r    <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			addr_r    <= addr_nxt;
			soft_r    <= soft_nxt;
			tstart_r  <= tstart_nxt;
			latch_r   <= latch_nxt;
			os_prev_r <= os_prev_nxt;
			done_r    <= done_nxt;
		end
	end

	assign scan_busy   = (state_r != logic_eval_pkg::ST_IDLE);
	assign scan_done   = done_r;
	assign syntax_err  = dup_err;
	assign timer_start = tstart_r;
	assign soft_output = soft_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_latch_rst;
		ev && entry.op == logic_eval_pkg::OP_LATCH && stk.top[0];
	endsequence

	sequence s_latch_idle;
		ev && entry.op == logic_eval_pkg::OP_LATCH && !stk.top[0] && !stk.top[1];
	endsequence

	a_latch_reset_dom: assert property (s_latch_rst |=> !stk.top[0])
		else $error("latch output true with reset input true");
	a_latch_hold: assert property (s_latch_idle |=> stk.top[0] == $past(latch_r[entry.arg[3:0]]))
		else $error("latch did not hold its state");
	a_xor_exact: assert property (ev && entry.op == logic_eval_pkg::OP_XOR
		|=> stk.top[0] == ($past(stk.top[0]) ^ $past(stk.top[1])))
		else $error("xor result wrong");
	a_and_gate: assert property (ev && entry.op == logic_eval_pkg::OP_AND && entry.arg == 7'h03
		|=> stk.top[0] == (&$past(stk.top[2:0])))
		else $error("three input and result wrong");
	a_assign_ends: assert property (ev && entry.op == logic_eval_pkg::OP_ASSIGN && entry.arg == 7'h00
		|=> stk.top == 16'h0000 && soft_r[0] == $past(stk.top[0]))
		else $error("assignment did not store and end equation");
	a_timer_start: assert property (ev && entry.op == logic_eval_pkg::OP_TIMER
		|=> tstart_r[$past(entry.arg[4:0])] == $past(stk.top[0]))
		else $error("timer not started by preceding result");
	a_end_stops: assert property (ev && entry.op == logic_eval_pkg::OP_END
		|=> state_r == logic_eval_pkg::ST_IDLE && scan_done ##1 !scan_done)
		else $error("end marker did not stop the pass");
	a_entry_order: assert property (ev && entry.op != logic_eval_pkg::OP_END && !is_last
		|=> addr_r == $past(addr_r) + 9'h001)
		else $error("entries not walked in order");
	a_write_recompile: assert property (set_wr
		|=> state_r == logic_eval_pkg::ST_COMPILE && latch_r == '0 && addr_r == 9'h000)
		else $error("write did not recompile and clear latches");
	a_scan_start: assert property (state_r == logic_eval_pkg::ST_IDLE && scan_stb && !dup_err && !set_wr
		|=> state_r == logic_eval_pkg::ST_EVAL && stk.top == 16'h0000)
		else $error("scan strobe did not start a clean pass");
endmodule

// ==== test/tb_logic_evaluator.sv ====
// Self-checking bench for the postfix logic evaluator, driving its ports directly
module tb_logic_evaluator;
	timeunit 1ns;
	timeprecision 1ps;
	logic         clk;
	logic         rst_n;
	logic         set_wr;
	logic         scan_stb;
	logic         scan_busy;
	logic         scan_done;
	logic         syntax_err;
	logic [8:0]   set_addr;
	logic [10:0]  set_data;
	logic [127:0] operand_in;
	logic [31:0]  timer_start;
	logic [31:0]  timer_out;
	logic [95:0]  soft_output;
	int           miscompares;
	int           checked;
	int           wa;
	int           n;

	logic_evaluator uut (
		.clk         (clk),
		.rst_n       (rst_n),
		.set_wr      (set_wr),
		.set_addr    (set_addr),
		.set_data    (set_data),
		.scan_stb    (scan_stb),
		.scan_busy   (scan_busy),
		.scan_done   (scan_done),
		.syntax_err  (syntax_err),
		.operand_in  (operand_in),
		.timer_start (timer_start),
		.timer_out   (timer_out),
		.soft_output (soft_output)
	);

	// Free-running 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// One-bit result compare; case inequality so unknowns never match
	task automatic chk(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask

	// Cycle count compare
	task automatic chk_cnt(input string what, input int exp, input int got);
		checked++;
		if (got != exp) begin
			miscompares++;
			$display("ERROR %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// Verdict and end of run
	task automatic end_sim();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Writes hold the strobe high back to back; the list index runs on
	task automatic put(input logic_eval_pkg::op_type op, input logic [6:0] arg);
		@(posedge clk);
		set_wr   <= 1'b1;
		set_addr <= wa[8:0];
		set_data <= {op, arg};
		wa++;
	endtask

	// Terminate the list, drop the strobe and wait for compile to finish
	task automatic close_list();
		put(logic_eval_pkg::OP_END, 7'h00);
		@(posedge clk);
		set_wr <= 1'b0;
		#1;
		for (int i = 0; i < 600 && scan_busy !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
		chk("compile_idle", 1'b0, scan_busy);
		wa = 0;
	endtask

	// One pass; operands land with the strobe, n counts edges to done
	task automatic scan(input logic [127:0] in_v, input logic [31:0] t_v, input logic exp_done);
		@(posedge clk);
		operand_in <= in_v;
		timer_out  <= t_v;
		scan_stb   <= 1'b1;
		@(posedge clk);
		scan_stb <= 1'b0;
		#1;
		n = 0;
		while (scan_done !== 1'b1 && n < 60) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("scan_done", exp_done, scan_done);
	endtask

	// Reset held three cycles, outputs checked cleared
	task automatic t_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk("soft_zero", 1'b1, soft_output === 96'h0);
		chk("start_zero", 1'b1, timer_start === 32'h0);
		repeat (2) @(posedge clk);
	endtask

	// Every gate over all input combinations; bits 3..15 held high for the wide AND
	task automatic t_gates();
		logic [2:0]             v;
		int                     e;
		logic_eval_pkg::op_type g_op [3];
		g_op = '{logic_eval_pkg::OP_NOR, logic_eval_pkg::OP_NAND, logic_eval_pkg::OP_XOR};
		for (int i = 0; i < 16; i++) put(logic_eval_pkg::OP_IN, 7'(i));
		put(logic_eval_pkg::OP_AND, 7'h10);
		put(logic_eval_pkg::OP_ASSIGN, 7'h00);
		for (int i = 0; i < 3; i++) put(logic_eval_pkg::OP_IN, 7'(i));
		put(logic_eval_pkg::OP_AND, 7'h03);
		put(logic_eval_pkg::OP_ASSIGN, 7'h01);
		for (int g = 0; g < 3; g++) begin
			put(logic_eval_pkg::OP_IN, 7'h00);
			put(logic_eval_pkg::OP_IN, 7'h01);
			put(g_op[g], 7'h02);
			put(logic_eval_pkg::OP_ASSIGN, 7'(g + 2));
		end
		for (int i = 0; i < 3; i++) put(logic_eval_pkg::OP_IN, 7'(i));
		put(logic_eval_pkg::OP_OR, 7'h03);
		put(logic_eval_pkg::OP_ASSIGN, 7'h05);
		put(logic_eval_pkg::OP_IN, 7'h00);
		put(logic_eval_pkg::OP_NOT, 7'h00);
		put(logic_eval_pkg::OP_ASSIGN, 7'h06);
		// A stale stack would leak input 0 into the next equation
		put(logic_eval_pkg::OP_IN, 7'h00);
		put(logic_eval_pkg::OP_ASSIGN, 7'h07);
		put(logic_eval_pkg::OP_IN, 7'h01);
		put(logic_eval_pkg::OP_OR, 7'h02);
		put(logic_eval_pkg::OP_ASSIGN, 7'h08);
		e = wa;
		close_list();
		for (int k = 0; k < 8; k++) begin
			v = 3'(k);
			scan({112'h0, 13'h1FFF, v}, 32'h0, 1'b1);
			chk_cnt("done_delay", e + 1, n);
			chk("and16", &v, soft_output[0]);
			chk("and3", &v, soft_output[1]);
			chk("nor2", ~(v[0] | v[1]), soft_output[2]);
			chk("nand2", ~(v[0] & v[1]), soft_output[3]);
			chk("xor2", v[0] ^ v[1], soft_output[4]);
			chk("or3", |v, soft_output[5]);
			chk("not", ~v[0], soft_output[6]);
			chk("fresh_eq", v[1], soft_output[8]);
		end
	endtask

	// Timer start follows the newest result, its output is pushed back
	task automatic t_timer();
		put(logic_eval_pkg::OP_IN, 7'h00);
		put(logic_eval_pkg::OP_TIMER, 7'h05);
		put(logic_eval_pkg::OP_ASSIGN, 7'h07);
		close_list();
		scan(128'h1, 32'h0000_0020, 1'b1);
		chk("start5_on", 1'b1, timer_start[5]);
		chk("start4_off", 1'b0, timer_start[4]);
		chk("tmr_out_on", 1'b1, soft_output[7]);
		scan(128'h0, 32'h0, 1'b1);
		chk("start5_off", 1'b0, timer_start[5]);
		chk("tmr_out_off", 1'b0, soft_output[7]);
	endtask

	// Repeated assignment or timer, and an out-of-range target, block scans
	task automatic t_syntax();
		for (int c = 0; c < 4; c++) begin
			put(logic_eval_pkg::OP_IN, 7'h00);
			if (c == 1) put(logic_eval_pkg::OP_TIMER, 7'h03);
			put(logic_eval_pkg::OP_ASSIGN, c == 2 ? 7'h60 : 7'h02);
			if (c < 2) begin
				put(logic_eval_pkg::OP_IN, 7'h01);
				if (c == 1) put(logic_eval_pkg::OP_TIMER, 7'h03);
				put(logic_eval_pkg::OP_ASSIGN, c == 1 ? 7'h01 : 7'h02);
			end
			close_list();
			chk("syntax_err", c != 3, syntax_err);
			scan(128'h1, 32'h0, c == 3);
		end
		chk("clean_assign", 1'b1, soft_output[2]);
	endtask

	// Read-before-assign sees last pass; entries past the first END never run
	task automatic t_order();
		put(logic_eval_pkg::OP_SOFT, 7'h00);
		put(logic_eval_pkg::OP_ASSIGN, 7'h01);
		put(logic_eval_pkg::OP_IN, 7'h00);
		put(logic_eval_pkg::OP_ASSIGN, 7'h00);
		put(logic_eval_pkg::OP_END, 7'h00);
		put(logic_eval_pkg::OP_IN, 7'h00);
		put(logic_eval_pkg::OP_ASSIGN, 7'h03);
		close_list();
		scan(128'h0, 32'h0, 1'b1);
		scan(128'h1, 32'h0, 1'b1);
		chk("feedback_old", 1'b0, soft_output[1]);
		chk("assign_new", 1'b1, soft_output[0]);
		chk("past_end", 1'b0, soft_output[3]);
		scan(128'h1, 32'h0, 1'b1);
		chk("feedback_new", 1'b1, soft_output[1]);
	endtask

	// Rising, falling and dual one-shots over the input sequence 0,1,1,0
	task automatic t_oneshot();
		logic_eval_pkg::op_type os_op [3];
		logic [3:0]             seq;
		logic [3:0]             er;
		logic [3:0]             ef;
		logic [3:0]             eb;
		os_op = '{logic_eval_pkg::OP_OS_RISE, logic_eval_pkg::OP_OS_FALL, logic_eval_pkg::OP_OS_BOTH};
		seq   = 4'h6;
		er    = 4'h2;
		ef    = 4'h8;
		eb    = 4'hA;
		for (int m = 0; m < 3; m++) begin
			put(logic_eval_pkg::OP_IN, 7'h00);
			put(os_op[m], 7'(m));
			put(logic_eval_pkg::OP_ASSIGN, 7'(m));
		end
		close_list();
		for (int k = 0; k < 4; k++) begin
			scan(128'(seq[k]), 32'h0, 1'b1);
			chk("os_rise", er[k], soft_output[0]);
			chk("os_fall", ef[k], soft_output[1]);
			chk("os_both", eb[k], soft_output[2]);
		end
	endtask

	// Latch list: input 0 sets, input 1 resets
	task automatic mk_latch();
		put(logic_eval_pkg::OP_IN, 7'h00);
		put(logic_eval_pkg::OP_IN, 7'h01);
		put(logic_eval_pkg::OP_LATCH, 7'h00);
		put(logic_eval_pkg::OP_ASSIGN, 7'h00);
		close_list();
	endtask

	// Set, hold, reset-dominant, then cleared by a rewrite and by a reset
	task automatic t_latch();
		logic [9:0] sr;
		logic [4:0] ex;
		sr = 10'h131;
		ex = 5'h13;
		mk_latch();
		for (int k = 0; k < 5; k++) begin
			scan(128'(sr[2*k+:2]), 32'h0, 1'b1);
			chk("latch", ex[k], soft_output[0]);
		end
		mk_latch();
		scan(128'h0, 32'h0, 1'b1);
		chk("latch_rewrite", 1'b0, soft_output[0]);
		scan(128'h1, 32'h0, 1'b1);
		t_reset();
		mk_latch();
		scan(128'h0, 32'h0, 1'b1);
		chk("latch_power", 1'b0, soft_output[0]);
	endtask

	// Cuts a hang short well beyond the expected run length
	initial begin
		#1000000;
		miscompares++;
		end_sim();
	end

	// Main sequence
	initial begin
		rst_n      = 1'b0;
		set_wr     = 1'b0;
		set_addr   = 9'h000;
		set_data   = 11'h000;
		scan_stb   = 1'b0;
		operand_in = 128'h0;
		timer_out  = 32'h0;
		wa         = 0;
		t_reset();
		t_gates();
		t_timer();
		t_syntax();
		t_order();
		t_oneshot();
		t_latch();
		end_sim();
	end
endmodule
